// ---- logic/tls_defines.vh ----
/*
 * Constants for the transient level sequencer: register offsets, field
 * positions, reset values, mode codes and timing figures.
 * Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef TLS_DEFINES_VH
`define TLS_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TLS_OFF_CTRL 8'h00
`define TLS_OFF_LOWER 8'h04
`define TLS_OFF_UPPER 8'h08
`define TLS_OFF_LDWELL 8'h0C
`define TLS_OFF_UDWELL 8'h10
`define TLS_OFF_RISE 8'h14
`define TLS_OFF_FALL 8'h18
`define TLS_OFF_CMD 8'h1C
`define TLS_OFF_STATUS 8'h20
`define TLS_OFF_SETPT 8'h24

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TLS_CTRL_MODE_LSB 0
`define TLS_CTRL_MODE_MSB 1
`define TLS_CTRL_SRC_LSB 2
`define TLS_CTRL_SRC_MSB 3
`define TLS_CTRL_INPUT_BIT 4

// Command register bits (write one to act, self clearing)
`define TLS_CMD_ARM_BIT 0
`define TLS_CMD_BUSTRG_BIT 1
`define TLS_CMD_IMM_BIT 2

// ----------------------------------------------------------------------
// Mode and trigger source codes
// ----------------------------------------------------------------------
`define TLS_MODE_CONT 2'h0
`define TLS_MODE_PULSE 2'h1
`define TLS_MODE_TOGGLE 2'h2
`define TLS_SRC_BUS 2'h0
`define TLS_SRC_EXT 2'h1
`define TLS_SRC_HOLD 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TLS_RST_CTRL 5'h00
`define TLS_RST_LEVEL 16'h0000
`define TLS_RST_TIME 20'h00001

// ----------------------------------------------------------------------
// Timing: one time unit is 10 us, times 1..1000000 units (10 us .. 10 s)
// ----------------------------------------------------------------------
`define TLS_CLK_HZ 10000000
`define TLS_TICK_US 10
`define TLS_TICK_CYC ((`TLS_CLK_HZ / 1000000) * `TLS_TICK_US)
`define TLS_TIME_MIN 20'h00001
`define TLS_TIME_MAX 20'hF4240

`endif

// ---- logic/tls_sequencer.v ----
/*
 * Transient level sequencer with an AXI4-Lite register slave. Drives a
 * set-point between a lower and an upper level in continuous, pulsed or
 * toggled mode, with programmed ramp and dwell times.
 * Assumes one 10 MHz clock, a synchronous active-low reset, and an
 * asynchronous TTL trigger pin that needs synchronising.
 */
//
// Summary of operation
// (R1) Continuous mode cycles freely, triggers ignored
// (R2) Cycle: rise, upper dwell, fall, lower dwell
// (R3) Parameters: levels, dwells, ramps, mode selector
// (R4) Mode selectable by remote register write
// (R5) Pulse: rise, upper dwell, fall per trigger
// (R6) Pulsed mode rests at lower level
// (R7) Pulsed trigger accepted only when resting low
// (R8) One accepted trigger gives exactly one pulse
// (R9) Triggers during a pulse are dropped
// (R10) Pulsed/toggled triggers need prior arming
// (R11) Trigger from external pin or bus command
// (R12) Switch-on in pulsed/toggled starts low
// (R13) Toggle moves to other level via ramp
// (R14) Toggle holds level, alternates up and down
// (R15) Times 10us to 10s, 10us steps
// (R16) External trigger on falling pin edge
// (R17) Hold source: only immediate command triggers
// (R18) Ramps step linearly to target level
// (R19) Input off stops, restart from low
`timescale 1ns/100ps
`include "tls_defines.vh"

module tls_sequencer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External trigger pin, active falling edge
  input wire ext_trig_pin,
  // Set-point to the regulation loop
  output reg [15:0] setpoint_r
);

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  localparam ST_OFF = 3'h0;
  localparam ST_LOW = 3'h1;
  localparam ST_RISE = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_FALL = 3'h4;

  // ----------------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------------
  reg [1:0] mode_r; // Operating mode
  reg [1:0] src_r; // Trigger source
  reg input_on_r; // Input switched on
  reg [15:0] lower_setpoint_r; // Lower level
  reg [15:0] upper_setpoint_r; // Upper level
  reg [19:0] lower_dwell_r; // Lower hold time, 10 us units
  reg [19:0] upper_dwell_r; // Upper hold time, 10 us units
  reg [19:0] ramp_up_time_r; // Rise time, 10 us units
  reg [19:0] ramp_down_time_r; // Fall time, 10 us units
  reg armed_r; // Trigger system armed
  reg bus_trg_r; // One-cycle bus trigger request
  reg imm_trg_r; // One-cycle immediate trigger request

  // Sequencer state
  reg [2:0] state_r;
  reg [6:0] tick_cnt_r; // Divides the clock to 10 us ticks
  reg [19:0] phase_cnt_r; // Ticks elapsed in current phase
  reg at_upper_r; // Toggle mode: last level reached

  // Trigger pin synchroniser, three stages
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_s3_r;
  reg pin_lvl_r; // Filtered pin level

  // Bus handshake latches
  reg aw_have_r;
  reg w_have_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Clamp a written time into the legal span
  function [19:0] clamp_time;
    input [31:0] v;
    begin
      if (v[19:0] < `TLS_TIME_MIN || v[31:20] != 12'h000) begin
        clamp_time = (v[31:20] != 12'h000) ? `TLS_TIME_MAX : `TLS_TIME_MIN;
      end else if (v[19:0] > `TLS_TIME_MAX) begin
        clamp_time = `TLS_TIME_MAX;
      end else begin
        clamp_time = v[19:0];
      end
    end
  endfunction

  // Linear interpolation between two levels, elapsed over total
  function [15:0] interp;
    input [15:0] from;
    input [15:0] to;
    input [19:0] num;
    input [19:0] den;
    reg [36:0] prod;
    reg [15:0] diff;
    begin
      diff = (to >= from) ? (to - from) : (from - to);
      prod = ({21'h000000, diff} * {17'h00000, num}) / {17'h00000, den};
      interp = (to >= from) ? (from + prod[15:0]) : (from - prod[15:0]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------------
  wire tick = (tick_cnt_r == (`TLS_TICK_CYC - 1)); // see (R15)
  wire pin_fall = pin_lvl_r && (pin_s2_r == pin_s3_r) && !pin_s3_r;
  wire src_trig =
    (src_r == `TLS_SRC_EXT && pin_fall) || // see (R16)
    (src_r == `TLS_SRC_BUS && bus_trg_r) || // see (R11)
    imm_trg_r; // see (R17)
  // Triggers only count once armed, and never in continuous mode
  wire trig = src_trig && armed_r && mode_r != `TLS_MODE_CONT; // see (R10)

  // Pin synchroniser: change counts once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
      pin_lvl_r <= 1'b1;
    end else begin
      pin_s1_r <= ext_trig_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_lvl_r <= pin_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Ramps recompute from elapsed ticks so rounding never accumulates
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_OFF;
      tick_cnt_r <= 7'h00;
      phase_cnt_r <= 20'h00000;
      at_upper_r <= 1'b0;
      setpoint_r <= `TLS_RST_LEVEL;
    end else if (!input_on_r) begin
      // Input off stops everything; next start is from low
      state_r <= ST_OFF; // see (R19)
      tick_cnt_r <= 7'h00;
      phase_cnt_r <= 20'h00000;
      at_upper_r <= 1'b0;
      setpoint_r <= lower_setpoint_r;
    end else begin
      tick_cnt_r <= tick ? 7'h00 : tick_cnt_r + 7'h01;
      case (state_r)
        ST_OFF: begin
          // All modes begin at the lower level
          state_r <= ST_LOW; // see (R12)
          phase_cnt_r <= 20'h00000;
          setpoint_r <= lower_setpoint_r;
        end
        ST_LOW: begin
          setpoint_r <= lower_setpoint_r; // see (R6)
          if (mode_r == `TLS_MODE_CONT) begin
            // Free running, lower dwell then rise
            if (tick) begin
              phase_cnt_r <= phase_cnt_r + 20'h00001;
              if (phase_cnt_r + 20'h00001 >= lower_dwell_r) begin
                state_r <= ST_RISE; // see (R1) (R2)
                phase_cnt_r <= 20'h00000;
              end
            end
          end else if (trig) begin
            // Pulsed triggers accepted only here, at rest low; one pulse per trigger
            state_r <= ST_RISE; // see (R5) (R7) (R8) (R13) (R14)
            phase_cnt_r <= 20'h00000;
          end
        end
        ST_RISE: begin
          // Triggers arriving here are simply dropped
          if (tick) begin // see (R9)
            phase_cnt_r <= phase_cnt_r + 20'h00001;
            setpoint_r <= interp(lower_setpoint_r, upper_setpoint_r,
              phase_cnt_r + 20'h00001, ramp_up_time_r); // see (R18)
            if (phase_cnt_r + 20'h00001 >= ramp_up_time_r) begin
              state_r <= ST_HIGH;
              phase_cnt_r <= 20'h00000;
              setpoint_r <= upper_setpoint_r;
              at_upper_r <= 1'b1;
            end
          end
        end
        ST_HIGH: begin
          setpoint_r <= upper_setpoint_r;
          if (mode_r == `TLS_MODE_TOGGLE) begin
            // Hold indefinitely until the next trigger
            if (trig) begin // see (R14)
              state_r <= ST_FALL;
              phase_cnt_r <= 20'h00000;
            end
          end else if (tick) begin
            // Upper dwell, then fall; pulse ignores triggers
            phase_cnt_r <= phase_cnt_r + 20'h00001; // see (R9)
            if (phase_cnt_r + 20'h00001 >= upper_dwell_r) begin
              state_r <= ST_FALL; // see (R2) (R5)
              phase_cnt_r <= 20'h00000;
            end
          end
        end
        ST_FALL: begin
          if (tick) begin
            phase_cnt_r <= phase_cnt_r + 20'h00001;
            setpoint_r <= interp(upper_setpoint_r, lower_setpoint_r,
              phase_cnt_r + 20'h00001, ramp_down_time_r); // see (R18)
            if (phase_cnt_r + 20'h00001 >= ramp_down_time_r) begin
              state_r <= ST_LOW; // see (R6) (R13)
              phase_cnt_r <= 20'h00000;
              setpoint_r <= lower_setpoint_r;
              at_upper_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  // Address and data may arrive in either order; latch both, then act
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_full = (w_strb_r == 4'hF);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      mode_r <= `TLS_MODE_CONT;
      src_r <= `TLS_SRC_BUS;
      input_on_r <= 1'b0;
      lower_setpoint_r <= `TLS_RST_LEVEL;
      upper_setpoint_r <= `TLS_RST_LEVEL;
      lower_dwell_r <= `TLS_RST_TIME;
      upper_dwell_r <= `TLS_RST_TIME;
      ramp_up_time_r <= `TLS_RST_TIME;
      ramp_down_time_r <= `TLS_RST_TIME;
      armed_r <= 1'b0;
      bus_trg_r <= 1'b0;
      imm_trg_r <= 1'b0;
    end else begin
      bus_trg_r <= 1'b0;
      imm_trg_r <= 1'b0;
      // Ready pulses one cycle when a channel is taken
      s_axi_awready <= !aw_have_r && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_have_r && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Arming is spent only on a trigger the sequencer acts on; one
      // dropped mid-pulse must leave the arm standing
      if (trig && (state_r == ST_LOW ||
          (state_r == ST_HIGH && mode_r == `TLS_MODE_TOGGLE))) begin
        armed_r <= 1'b0; // see (R10) (R9)
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // Partial writes are ignored; whole words only
        if (wr_full) begin
          case (aw_addr_r)
            `TLS_OFF_CTRL: begin
              mode_r <= w_data_r[`TLS_CTRL_MODE_MSB:`TLS_CTRL_MODE_LSB];
              src_r <= w_data_r[`TLS_CTRL_SRC_MSB:`TLS_CTRL_SRC_LSB];
              input_on_r <= w_data_r[`TLS_CTRL_INPUT_BIT]; // see (R4)
            end
            `TLS_OFF_LOWER: lower_setpoint_r <= w_data_r[15:0]; // see (R3)
            `TLS_OFF_UPPER: upper_setpoint_r <= w_data_r[15:0];
            `TLS_OFF_LDWELL: lower_dwell_r <= clamp_time(w_data_r);
            `TLS_OFF_UDWELL: upper_dwell_r <= clamp_time(w_data_r);
            `TLS_OFF_RISE: ramp_up_time_r <= clamp_time(w_data_r);
            `TLS_OFF_FALL: ramp_down_time_r <= clamp_time(w_data_r);
            `TLS_OFF_CMD: begin
              if (w_data_r[`TLS_CMD_ARM_BIT]) begin
                armed_r <= 1'b1;
              end
              bus_trg_r <= w_data_r[`TLS_CMD_BUSTRG_BIT];
              imm_trg_r <= w_data_r[`TLS_CMD_IMM_BIT];
            end
            `TLS_OFF_STATUS: s_axi_bresp <= 2'h2;
            `TLS_OFF_SETPT: s_axi_bresp <= 2'h2;
            default: s_axi_bresp <= 2'h3;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `TLS_OFF_CTRL: s_axi_rdata <= {27'h0000000, input_on_r, src_r,
            mode_r};
          `TLS_OFF_LOWER: s_axi_rdata <= {16'h0000, lower_setpoint_r};
          `TLS_OFF_UPPER: s_axi_rdata <= {16'h0000, upper_setpoint_r};
          `TLS_OFF_LDWELL: s_axi_rdata <= {12'h000, lower_dwell_r};
          `TLS_OFF_UDWELL: s_axi_rdata <= {12'h000, upper_dwell_r};
          `TLS_OFF_RISE: s_axi_rdata <= {12'h000, ramp_up_time_r};
          `TLS_OFF_FALL: s_axi_rdata <= {12'h000, ramp_down_time_r};
          `TLS_OFF_CMD: s_axi_rdata <= 32'h00000000;
          `TLS_OFF_STATUS: s_axi_rdata <= {26'h0000000, at_upper_r,
            armed_r, 1'b0, state_r};
          `TLS_OFF_SETPT: s_axi_rdata <= {16'h0000, setpoint_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end
    end
  end

endmodule // tls_sequencer

// ---- test/tls_seq_monitor.sv ----
/* Checker for the sequencer's register bus and set-point.
   Bound onto tls_sequencer; sees only that module's ports. */
`timescale 1ns/100ps
module tls_seq_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Set-point
  input wire [15:0] setpoint_r
);
  // ------------------------------------------
  // One clock domain for every check
  // ------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans;
    s_wr_take |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer missing");
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_r_cause;
    $rose(s_axi_rvalid) |-> $past(s_axi_arready);
  endproperty
  a_r_cause: assert property (p_r_cause)
    else $error("read answer without request");
  property p_b_cause;
    $rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready, 2) ||
      $past(s_axi_wvalid && s_axi_wready, 2);
  endproperty
  a_b_cause: assert property (p_b_cause)
    else $error("write answer without data");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse)
    else $error("awready held");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("arready held");
  // Ramp steps come at least four cycles apart, never on adjacent cycles
  property p_sp_step;
    $changed(setpoint_r) |=> $stable(setpoint_r) [*3];
  endproperty
  a_sp_step: assert property (p_sp_step)
    else $error("set-point stepped too fast");
endmodule // tls_seq_monitor

// ---- test/tls_trig_model.sv ----
/* External trigger source feeding the sequencer's TTL pin.
   Assumes the bench asks for a trigger with a one-cycle fire pulse. */
`timescale 1ns/100ps
module tls_trig_model (
  // Clock
  input wire aclk,
  // Request from the bench
  input wire fire,
  // Trigger pin, idles high like a pulled-up TTL line
  output reg ext_trig_pin = 1'b1
);
  integer n = 0; // Low-time counter
  // Low long enough to pass the pin synchroniser
  always @(posedge aclk) begin
    if (fire) begin
      ext_trig_pin <= 1'b0;
      n <= 6;
    end else if (n > 0) begin
      n <= n - 1;
    end else begin
      ext_trig_pin <= 1'b1;
    end
  end
endmodule // tls_trig_model

// ---- test/tls_sequencer_bench.sv ----
/* Self-checking bench for tls_sequencer: bus master, trigger source,
   expected set-points kept in a queue. Assumes a 100-cycle tick. */
`timescale 1ns/100ps
`include "tls_defines.vh"
module tls_sequencer_bench;
  // ------------------------------------------
  // Design signals
  // ------------------------------------------
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, fire;
  reg s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, ext_trig_pin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] setpoint_r;
  integer failures, samples_checked, n;
  reg [31:0] seed, rd_d;
  reg [1:0] rsp;
  reg [15:0] lo, hi;
  int exp_q[$]; // Expected set-points, oldest first
  tls_sequencer dut (.*);
  tls_trig_model u_trig (.aclk(aclk), .fire(fire),
    .ext_trig_pin(ext_trig_pin));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: both halves offered, each dropped once taken
  task wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // Wait a bounded time for the next expected set-point
  task wsp(input integer m);
    integer i;
    for (i = 0; i < m && setpoint_r !== exp_q[0]; i++) @(posedge aclk);
    chk(setpoint_r, exp_q.pop_front());
  endtask
  task pin;
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask
  // Ticks spent at the upper level, rounded
  task span_hi;
    n = 0;
    while (setpoint_r === hi && n < 2000) begin
      @(posedge aclk);
      n = n + 1;
    end
    chk((n + 50) / 100, 3);
  endtask
  initial begin
    #(30000 * 100);
    failures = failures + 1;
    end_sim;
  end
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, fire} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    seed = 32'h7858;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TLS_OFF_SETPT);
    chk(rd_d, 32'h0);
    rd(`TLS_OFF_RISE);
    chk(rd_d, `TLS_RST_TIME);
    rd(8'h40);
    chk(rsp, 2'h3);
    wr(`TLS_OFF_STATUS, 32'h0);
    chk(rsp, 2'h2);
    wr(`TLS_OFF_RISE, 32'h0);
    rd(`TLS_OFF_RISE);
    chk(rd_d, `TLS_TIME_MIN);
    wr(`TLS_OFF_RISE, 32'h000FFFFF);
    rd(`TLS_OFF_RISE);
    chk(rd_d, `TLS_TIME_MAX);
    seed = xs(seed);
    lo = {1'b0, seed[14:0]};
    seed = xs(seed);
    hi = {1'b1, seed[14:0]};
    wr(`TLS_OFF_LOWER, lo);
    wr(`TLS_OFF_UPPER, hi);
    wr(`TLS_OFF_LDWELL, 32'h1);
    wr(`TLS_OFF_UDWELL, 32'h2);
    wr(`TLS_OFF_RISE, 32'h2);
    wr(`TLS_OFF_FALL, 32'h1);
    // Pulsed, bus source: unarmed, then armed, retrigger mid-pulse
    wr(`TLS_OFF_CTRL, 32'h11);
    exp_q.push_back(lo);
    wsp(20);
    wr(`TLS_OFF_CMD, 32'h2);
    repeat (300) @(posedge aclk);
    exp_q.push_back(lo);
    wsp(0);
    wr(`TLS_OFF_CMD, 32'h1);
    wr(`TLS_OFF_CMD, 32'h2);
    exp_q.push_back(hi);
    wsp(400);
    wr(`TLS_OFF_CMD, 32'h3);
    span_hi;
    exp_q.push_back(lo);
    wsp(50);
    repeat (600) @(posedge aclk);
    exp_q.push_back(lo);
    wsp(0);
    rd(`TLS_OFF_STATUS);
    chk(rd_d & 32'h37, 32'h11);
    // Toggled, external pin
    wr(`TLS_OFF_CTRL, 32'h16);
    wr(`TLS_OFF_CMD, 32'h1);
    pin;
    exp_q.push_back(hi);
    wsp(400);
    repeat (500) @(posedge aclk);
    chk(setpoint_r, hi);
    pin;
    repeat (300) @(posedge aclk);
    chk(setpoint_r, hi);
    wr(`TLS_OFF_CMD, 32'h1);
    pin;
    exp_q.push_back(lo);
    wsp(300);
    // Hold source: bus trigger dropped, immediate fires
    wr(`TLS_OFF_CTRL, 32'h1A);
    wr(`TLS_OFF_CMD, 32'h1);
    wr(`TLS_OFF_CMD, 32'h2);
    repeat (300) @(posedge aclk);
    chk(setpoint_r, lo);
    wr(`TLS_OFF_CMD, 32'h4);
    exp_q.push_back(hi);
    wsp(400);
    wr(`TLS_OFF_CTRL, 32'h0A);
    exp_q.push_back(lo);
    wsp(10);
    rd(`TLS_OFF_STATUS);
    chk(rd_d[2:0], 3'h0);
    // Continuous: free running, trigger ignored, linear ramp
    wr(`TLS_OFF_CTRL, 32'h14);
    wr(`TLS_OFF_CMD, 32'h1);
    pin;
    for (n = 0; n < 300 && setpoint_r === lo; n++) @(posedge aclk);
    chk(setpoint_r, lo + (hi - lo) / 2);
    exp_q.push_back(hi);
    wsp(200);
    span_hi;
    exp_q.push_back(lo);
    exp_q.push_back(hi);
    wsp(50);
    wsp(400);
    end_sim;
  end
endmodule // tls_sequencer_bench
bind tls_sequencer tls_seq_monitor u_mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .setpoint_r);
